/* File: sim/adc_ctl_props.sv */
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module adc_ctl_props
    import adc_ctl_pkg::*;
#(
    parameter int STARTUP_CYCLES = 4
) (
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic [15:0] address_i,
    input wire logic        read_i,
    input wire logic        write_i,
    input wire logic [3:0]  byteenable_i,
    input wire logic [31:0] writedata_i,
    input wire logic [31:0] readdata_o,
    input wire logic        waitrequest_o,
    input wire logic        adc_on_o,
    input wire logic        sample_tick_o,
    input wire logic        conv_take_o,
    input wire logic        pos_high_range_o,
    input wire logic        neg_high_range_o,
    input wire logic [9:0]  pos_route_o,
    input wire logic [9:0]  neg_route_o,
    input wire ram_wr_t     ram_wr_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic [31:0] wd_q;

    // Write data of the previous edge, for checks one cycle after
    always_ff @(posedge sys_clk_i) wd_q <= writedata_i;

    // One-hot route of a select code; reserved codes route nothing
    function automatic logic [9:0] route_of(input logic [3:0] c);
        if (c <= SEL_PIN_LAST) return 10'h001 << c;
        if (c >= SEL_GND && c <= SEL_VREG_H) return 10'h040 << (c - SEL_GND);
        return 10'h000;
    endfunction

    // Full-word write or read that completes at this edge
    sequence wr_s(logic [15:0] a);
        write_i && !waitrequest_o && address_i == a && byteenable_i == 4'hF;
    endsequence
    sequence rd_s(logic [15:0] a);
        read_i && !waitrequest_o && address_i == a;
    endsequence

    a_pos_range: assert property (wr_s(OFF_CONV_CONFIG) |=>
        pos_high_range_o == wd_q[CFG_POS_HR]) else $error("P range wrong");
    a_neg_range: assert property (wr_s(OFF_CONV_CONFIG) |=>
        neg_high_range_o == wd_q[CFG_NEG_HR]) else $error("N range wrong");
    a_pos_route: assert property (wr_s(OFF_CONV_CONFIG) |=>
        pos_route_o == route_of(wd_q[CFG_POS_HI:CFG_POS_LO]))
        else $error("P route wrong");
    a_neg_route: assert property (wr_s(OFF_CONV_CONFIG) |=>
        neg_route_o == route_of(wd_q[CFG_NEG_HI:CFG_NEG_LO]))
        else $error("N route wrong");
    a_event_rsvd: assert property (rd_s(OFF_EVENT_FLAGS) or
        rd_s(OFF_EVENT_ENABLES) |-> readdata_o[31:5] == 27'h0
        && !readdata_o[0]) else $error("Event reserved bits set");
    a_rst_reads0: assert property (rd_s(OFF_DMA_CONTROL) |->
        !readdata_o[DMA_RST_BIT]) else $error("DMA reset bit reads one");
    a_dma_rst_quiet: assert property (wr_s(OFF_DMA_CONTROL) &&
        writedata_i[DMA_RST_BIT] |=> ##1 !ram_wr_o.valid [*8])
        else $error("Result written after DMA reset");
    a_take_to_ram: assert property (ram_wr_o.valid |->
        $past(conv_take_o, 2)) else $error("Result write without take");
    a_idle_quiet: assert property (!adc_on_o |->
        !sample_tick_o && !conv_take_o) else $error("Ticks while off");
endmodule

bind adc_event_and_control_regs adc_ctl_props #(
    .STARTUP_CYCLES(STARTUP_CYCLES)
) u_props (
    .sys_clk_i, .rst_i, .address_i, .read_i, .write_i, .byteenable_i,
    .writedata_i, .readdata_o, .waitrequest_o, .adc_on_o, .sample_tick_o,
    .conv_take_o, .pos_high_range_o, .neg_high_range_o, .pos_route_o,
    .neg_route_o, .ram_wr_o
);

/* File: sim/adc_event_and_control_regs_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_event_and_control_regs_tb;
    import adc_ctl_pkg::*;
    logic        sys_clk_i, rst_i, read_i, write_i, waitrequest_o, irq_o;
    logic        adc_on_o, sample_tick_o, conv_take_o;
    logic        pos_high_range_o, neg_high_range_o;
    logic [15:0] address_i, conv_data_i, cfg, gain, offs;
    logic [3:0]  byteenable_i;
    logic [31:0] writedata_i, readdata_o, q, rnd;
    logic [31:0] seed = 32'hB953;
    logic [9:0]  pos_route_o, neg_route_o;
    logic [4:0]  expf;
    ram_wr_t     ram_wr_o;
    logic [15:0] raws [$];
    int          tks [$];
    int          err_total = 0, checked = 0, tk = 0, cy = 0, n, i, smp;
    int          gmin = 1000, gmax = 0;
    longint      p;
    logic [15:0] ra [6] = '{OFF_EVENT_FLAGS, OFF_EVENT_ENABLES,
        OFF_CONV_CONFIG, OFF_OFFSET_TRIM, OFF_GAIN_TRIM, OFF_DMA_CONTROL};
    logic [31:0] rv [6] = '{0, 0, 32'h1800, 0, 32'h8000, 0};

    adc_event_and_control_regs #(.STARTUP_CYCLES(4)) uut (
        .sys_clk_i, .rst_i, .address_i, .read_i, .write_i, .byteenable_i,
        .writedata_i, .readdata_o, .waitrequest_o, .conv_data_i, .adc_on_o,
        .sample_tick_o, .conv_take_o, .pos_high_range_o, .neg_high_range_o,
        .pos_route_o, .neg_route_o, .ram_wr_o, .irq_o);
    ram_sink u_ram (.sys_clk_i, .ram_wr_i(ram_wr_o));

    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Tick counts per result and tick spacing; raw data for the model
    always @(posedge sys_clk_i) begin
        cy++;
        if (adc_on_o !== 1'b1) begin
            tk = 0;
            cy = -100000;
        end
        if (sample_tick_o === 1'b1) begin
            tk++;
            if (cy > 0) gmin = cy < gmin ? cy : gmin;
            if (cy > 0) gmax = cy > gmax ? cy : gmax;
            cy = 0;
        end
        if (conv_take_o === 1'b1) begin
            tks.push_back(tk);
            tk = 0;
            raws.push_back(conv_data_i);
        end
        conv_data_i <= 16'(xs());
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", s, e, g);
            err_total++;
        end
    endtask

    // One Avalon access; waits for waitrequest low under a bound
    task automatic bus(input logic w, input logic [15:0] a, input [31:0] d);
        int k;
        @(posedge sys_clk_i);
        address_i <= a;
        writedata_i <= d;
        write_i <= w;
        read_i <= !w;
        k = 0;
        do begin
            @(posedge sys_clk_i);
            k++;
        end while (waitrequest_o !== 1'b0 && k < 50);
        q = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
        if (k >= 50) begin
            err_total++;
            tally_and_finish();
        end
    endtask

    task automatic rd(input logic [15:0] a, input [31:0] e, input string s);
        bus(1'b0, a, 32'h0);
        chk(s, e, q);
    endtask

    initial begin
        rst_i = 1'b1;
        read_i = 1'b0;
        write_i = 1'b0;
        address_i = 16'h0;
        writedata_i = 32'h0;
        byteenable_i = 4'hF;
        conv_data_i = 16'h0;
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        // Reset values, gain included
        for (i = 0; i < 6; i++) rd(ra[i], rv[i], "reset value");
        $display("reset test done");
        // Enables keep their four positions; unmapped space is inert
        // Reserved enable bit 0 is always written as zero
        rnd = xs() & 32'hFFFF_FFFE;
        bus(1'b1, OFF_EVENT_ENABLES, rnd);
        rd(OFF_EVENT_ENABLES, rnd & 32'h1E, "enables");
        bus(1'b1, 16'h0100, 32'hFFFFFFFF);
        rd(16'h0100, 32'h0, "unmapped");
        bus(1'b1, OFF_EVENT_ENABLES, 32'h1E);
        $display("register test done");
        // Four-slot linear buffer, converter on with random settings
        offs = 16'(xs());
        gain = 16'(xs()) | 16'h8000;
        smp = xs() & 1;
        cfg = {3'(smp), 2'b11, 4'(xs()), 4'(xs()), 3'b001};
        // DMA reset first, then loaded just before the converter is switched on
        bus(1'b1, OFF_DMA_CONTROL, 32'h10);
        bus(1'b1, OFF_RESULT_COUNT, 32'h4);
        bus(1'b1, OFF_OFFSET_TRIM, {16'h0, offs});
        bus(1'b1, OFF_GAIN_TRIM, {16'h0, gain});
        bus(1'b1, OFF_DMA_CONTROL, 32'h1);
        bus(1'b1, OFF_CONV_CONFIG, {16'h0, cfg});
        rd(OFF_CONV_CONFIG, {16'h0, cfg}, "config");
        for (n = 0; n < 20000 && raws.size() < 5; n++) @(posedge sys_clk_i);
        // Stop the converter so no later result disturbs the flags
        bus(1'b1, OFF_CONV_CONFIG, {16'h0, cfg[15:1], 1'b0});
        if (n >= 20000) begin
            err_total++;
            tally_and_finish();
        end
        // Model: offset, gain, saturation, flags
        expf = 5'h16;
        for (i = 0; i < 5; i++) begin
            p = (longint'($signed(raws[i])) + longint'($signed(offs)))
                * longint'(gain);
            p = p >>> 15;
            if (p > 32767 || p < -32768) expf[3] = 1'b1;
            p = p > 32767 ? 32767 : (p < -32768 ? -32768 : p);
            if (i < 4) chk("ram data", {16'h0, 16'(p)}, u_ram.mem[i]);
        end
        chk("ram writes", 4, u_ram.n_wr);
        chk("first ticks", 64 << smp, tks[0]);
        chk("ticks", 32 << smp, tks[1]);
        chk("tick gap min", 8, gmin);
        chk("tick gap max", 8, gmax);
        chk("irq set", 1, irq_o);
        rd(OFF_EVENT_FLAGS, {27'h0, expf}, "flags");
        // Only reserved bit 0 set: no flag may clear
        bus(1'b1, OFF_EVENT_FLAGS, 32'h1);
        rd(OFF_EVENT_FLAGS, {27'h0, expf}, "flags kept");
        bus(1'b1, OFF_EVENT_FLAGS, 32'h1F);
        rd(OFF_EVENT_FLAGS, 32'h0, "flags cleared");
        chk("irq clear", 0, irq_o);
        rd(OFF_DMA_STATUS, 32'h2, "dma status");
        bus(1'b1, OFF_DMA_CONTROL, 32'h10);
        rd(OFF_DMA_STATUS, 32'h0, "dma status reset");
        rd(OFF_DMA_CONTROL, 32'h0, "dma control");
        $display("conversion test done");
        tally_and_finish();
    end
endmodule

/* File: sim/ram_sink.sv */
// Result memory on the far side of the result write port
`timescale 1ns/1ps
module ram_sink
    import adc_ctl_pkg::*;
(
    input wire logic    sys_clk_i,
    input wire ram_wr_t ram_wr_i
);
    logic [15:0] mem [0:15];
    int          n_wr = 0;

    // One slot per 16-bit result; unwritten slots stay unknown on purpose
    always @(posedge sys_clk_i) begin
        if (ram_wr_i.valid === 1'b1) begin
            mem[ram_wr_i.index[3:0]] <= ram_wr_i.data;
            n_wr <= n_wr + 1;
        end
    end
endmodule

/* File: verilog/adc_ctl_pkg.sv */
// Shared constants, register map and types for the converter control block
package adc_ctl_pkg;

    // Register byte addresses on the bus
    localparam logic [15:0] OFF_EVENT_FLAGS   = 16'hA810;
    localparam logic [15:0] OFF_EVENT_ENABLES = 16'hA850;
    localparam logic [15:0] OFF_CONV_CONFIG   = 16'hD004;
    localparam logic [15:0] OFF_OFFSET_TRIM   = 16'hD008;
    localparam logic [15:0] OFF_GAIN_TRIM     = 16'hD00C;
    localparam logic [15:0] OFF_DMA_CONTROL   = 16'hD010;
    localparam logic [15:0] OFF_DMA_STATUS    = 16'hD014;
    localparam logic [15:0] OFF_RESULT_COUNT  = 16'hD01C;
    localparam logic [15:0] OFF_DONE_COUNT    = 16'hD024;

    // Event flag and enable positions
    localparam int BIT_OVERFLOW  = 4;
    localparam int BIT_GAIN_CLIP = 3;
    localparam int BIT_BUF_FULL  = 2;
    localparam int BIT_BUF_HALF  = 1;
    localparam logic [4:0] EVENT_MASK = 5'h1E;

    // Conversion config fields
    localparam int CFG_SMP_HI  = 15;
    localparam int CFG_SMP_LO  = 13;
    localparam int CFG_POS_HR  = 12;
    localparam int CFG_NEG_HR  = 11;
    localparam int CFG_POS_HI  = 10;
    localparam int CFG_POS_LO  = 7;
    localparam int CFG_NEG_HI  = 6;
    localparam int CFG_NEG_LO  = 3;
    localparam int CFG_CLK_SEL = 2;
    localparam int CFG_ON      = 0;
    localparam logic [15:0] CFG_WMASK = 16'hFFFD;

    // DMA control and status fields
    localparam int DMA_RST_BIT  = 4;
    localparam int DMA_WRAP_BIT = 1;
    localparam int DMA_LOAD_BIT = 0;
    localparam int DST_OVF_BIT  = 1;
    localparam int DST_ACT_BIT  = 0;

    // Reset values
    localparam logic [15:0] CFG_RESET  = 16'h1800;
    localparam logic [15:0] GAIN_RESET = 16'h8000;
    localparam logic [15:0] OFFS_RESET = 16'h0000;

    // Input select codes
    localparam logic [3:0] SEL_PIN_LAST = 4'h5;
    localparam logic [3:0] SEL_GND      = 4'h8;
    localparam logic [3:0] SEL_VREG_H   = 4'hB;

    // Sample length base and gain binary point
    localparam logic [13:0] SMP_BASE    = 14'h0020;
    localparam int          GAIN_FRAC   = 15;

    // Timing
    localparam int CLK_HZ     = 50_000_000;
    localparam int FAST_HZ    = 6_000_000;
    localparam int SLOW_HZ    = 1_000_000;
    localparam int STARTUP_NS = 21_000;
    localparam int CLK_MHZ    = CLK_HZ / 1_000_000;
    localparam int STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;
    localparam logic [5:0] DIV_FAST = 6'(CLK_HZ / FAST_HZ);
    localparam logic [5:0] DIV_SLOW = 6'(CLK_HZ / SLOW_HZ);

    // Sequencer states
    typedef enum logic [2:0] {
        SQ_OFF  = 3'b001,
        SQ_WARM = 3'b010,
        SQ_CONV = 3'b100
    } seq_t;

    // Result write toward system RAM
    typedef struct packed {
        logic        valid;
        logic [12:0] index;
        logic [15:0] data;
    } ram_wr_t;

    // Whole block state
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [4:0]  flags;
        logic [4:0]  enables;
        logic [15:0] cfg;
        logic [15:0] offset;
        logic [15:0] gain;
        logic        wrap;
        logic        load;
        logic        dma_act;
        logic        dma_ovf;
        logic [12:0] ndt;
        logic [12:0] cndt;
        logic [12:0] idx;
        seq_t        seq;
        logic [5:0]  div;
        logic [13:0] cnt;
        logic        dbl;
        logic        res_valid;
        logic [15:0] res_data;
        ram_wr_t     ram;
    } state_t;

endpackage

/* File: verilog/adc_event_and_control_regs.sv */
// Converter sequencing, correction, result DMA and event registers
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module adc_event_and_control_regs
    import adc_ctl_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // Avalon-MM slave
    input  wire logic [15:0] address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [3:0]  byteenable_i,
    input  wire logic [31:0] writedata_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    // Analog converter side
    input  wire logic [15:0] conv_data_i,
    output logic             adc_on_o,
    output logic             sample_tick_o,
    output logic             conv_take_o,
    output logic             pos_high_range_o,
    output logic             neg_high_range_o,
    output logic      [9:0]  pos_route_o,
    output logic      [9:0]  neg_route_o,
    // Result write port toward RAM
    output ram_wr_t          ram_wr_o,
    output logic             irq_o
);

    state_t r, nxt;

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // Input select decode: bits 5..0 pins, 6 gnd, 7 half ref, 8 ref,
    // 9 half regulator; reserved codes route nothing
    function automatic logic [9:0] route_decode(input logic [3:0] code);
        logic [9:0] o;
        o = 10'h000;
        if (code <= SEL_PIN_LAST) begin
            o[code] = 1'b1;
        end else if (code >= SEL_GND && code <= SEL_VREG_H) begin
            o[4'(code - SEL_GND) + 4'h6] = 1'b1;
        end
        return o;
    endfunction

    // Sample clocks for one conversion, doubled after start or change
    function automatic logic [13:0] smp_len(input logic [2:0] f,
                                            input logic       dbl);
        logic [13:0] n;
        n = SMP_BASE << f;
        return dbl ? 14'(n << 1) : n;
    endfunction

    logic        wr_go;
    logic        rd_go;
    logic        tick;
    logic        conv_end;
    logic [31:0] cur;
    logic [31:0] wm;
    logic [4:0]  ev_set;
    logic [4:0]  ev_clr;
    logic [15:0] cfg_new;
    logic signed [16:0] sum;
    logic signed [33:0] prod;
    logic [18:0] scaled;
    logic        clip;
    logic [12:0] half_pt;

    // Bus handshake: one wait cycle, then the request is answered
    assign waitrequest_o = (read_i | write_i) & ~r.ack;
    assign wr_go         = write_i & r.ack;
    assign rd_go         = read_i & ~r.ack;
    assign readdata_o    = r.rdata;

    // Converter side drive
    assign adc_on_o         = (r.seq != SQ_OFF);
    assign pos_high_range_o = r.cfg[CFG_POS_HR];
    assign neg_high_range_o = r.cfg[CFG_NEG_HR];
    assign pos_route_o = route_decode(r.cfg[CFG_POS_HI:CFG_POS_LO]);
    assign neg_route_o = route_decode(r.cfg[CFG_NEG_HI:CFG_NEG_LO]);
    assign ram_wr_o    = r.ram;

    // Only enabled flags raise the request
    assign irq_o = |(r.flags & r.enables & EVENT_MASK);

    // Sample clock enable from the selected divider
    assign tick = (r.seq == SQ_CONV) &&
                  (r.div == (r.cfg[CFG_CLK_SEL] ? DIV_SLOW : DIV_FAST)
                   - 6'h01);
    assign sample_tick_o = tick;
    assign conv_end = tick &&
                      (r.cnt == smp_len(r.cfg[CFG_SMP_HI:CFG_SMP_LO], r.dbl)
                       - 14'h0001);
    assign conv_take_o = conv_end;

    // Offset then gain; the product keeps 19 integer bits for the clip test
    assign sum    = 17'(signed'(conv_data_i)) + 17'(signed'(r.offset));
    assign prod   = 34'(sum) * 34'(signed'({1'b0, r.gain}));
    assign scaled = prod[GAIN_FRAC +: 19];
    assign clip   = ~((&scaled[18:15]) | ~(|scaled[18:15]));

    // Half point for an odd count rounds the count down
    assign half_pt = (r.ndt >> 1) - 13'h0001;

    // Current value of the addressed register, reserved bits as zero
    always_comb begin
        cur = 32'h0000_0000;
        unique case (address_i)
            OFF_EVENT_FLAGS:   cur = {27'h0, r.flags & EVENT_MASK};
            OFF_EVENT_ENABLES: cur = {27'h0, r.enables & EVENT_MASK};
            OFF_CONV_CONFIG:   cur = {16'h0, r.cfg};
            OFF_OFFSET_TRIM:   cur = {16'h0, r.offset};
            OFF_GAIN_TRIM:     cur = {16'h0, r.gain};
            OFF_DMA_CONTROL:   cur = {30'h0, r.wrap, r.load};
            OFF_DMA_STATUS:    cur = {30'h0, r.dma_ovf, r.dma_act};
            OFF_RESULT_COUNT:  cur = {19'h0, r.ndt};
            OFF_DONE_COUNT:    cur = {19'h0, r.cndt};
            default:           cur = 32'h0000_0000;
        endcase
    end

    // Next state of the whole block
    always_comb begin
        nxt          = r;
        wm           = lane_merge(cur, writedata_i, byteenable_i);
        ev_set       = 5'h00;
        ev_clr       = 5'h00;
        cfg_new      = wm[15:0] & CFG_WMASK;
        nxt.ack      = (read_i | write_i) & ~r.ack;
        nxt.ram.valid = 1'b0;
        nxt.res_valid = 1'b0;
        if (rd_go) begin
            nxt.rdata = cur;
        end

        // Sample divider runs only while converting
        if (r.seq == SQ_CONV && !tick) begin
            nxt.div = r.div + 6'h01;
        end else begin
            nxt.div = 6'h00;
        end

        // Sequencer: warm-up delay, then doubled first conversion
        unique case (r.seq)
            SQ_OFF: begin
                nxt.cnt = 14'h0000;
            end
            SQ_WARM: begin
                if (r.cnt == 14'(STARTUP_CYCLES - 1)) begin
                    nxt.seq = SQ_CONV;
                    nxt.cnt = 14'h0000;
                    nxt.dbl = 1'b1;
                end else begin
                    nxt.cnt = r.cnt + 14'h0001;
                end
            end
            SQ_CONV: begin
                if (conv_end) begin
                    nxt.cnt = 14'h0000;
                    nxt.dbl = 1'b0;
                    nxt.res_valid = 1'b1;
                    nxt.res_data  = clip ? {scaled[18], {15{~scaled[18]}}}
                                         : scaled[15:0];
                    ev_set[BIT_GAIN_CLIP] = clip;
                end else if (tick) begin
                    nxt.cnt = r.cnt + 14'h0001;
                end
            end
        endcase

        // Corrected result goes to RAM or counts as overflow
        if (r.res_valid) begin
            if (r.dma_act) begin
                nxt.ram.valid = 1'b1;
                nxt.ram.index = r.idx;
                nxt.ram.data  = r.res_data;
                nxt.cndt      = r.idx + 13'h0001;
                nxt.idx       = r.idx + 13'h0001;
                if (r.ndt > 13'h0001 && r.idx == half_pt) begin
                    ev_set[BIT_BUF_HALF] = 1'b1;
                end
                if (r.idx == r.ndt - 13'h0001) begin
                    ev_set[BIT_BUF_FULL] = 1'b1;
                    nxt.idx = 13'h0000;
                    if (!r.wrap) begin
                        nxt.dma_act = 1'b0;
                    end
                end
            end else begin
                ev_set[BIT_OVERFLOW] = 1'b1;
                nxt.dma_ovf = 1'b1;
            end
        end

        // Pending load starts the DMA one cycle after the write
        if (r.load) begin
            nxt.load    = 1'b0;
            nxt.dma_act = 1'b1;
            nxt.idx     = 13'h0000;
            nxt.cndt    = 13'h0000;
        end

        // Register writes take effect on the answered edge
        if (wr_go) begin
            unique case (address_i)
                OFF_EVENT_FLAGS: begin
                    ev_clr = wm[4:0] & EVENT_MASK;
                end
                OFF_EVENT_ENABLES: begin
                    nxt.enables = wm[4:0] & EVENT_MASK;
                end
                OFF_CONV_CONFIG: begin
                    nxt.cfg = cfg_new;
                    if (!cfg_new[CFG_ON]) begin
                        nxt.seq = SQ_OFF;
                    end else if (r.seq == SQ_OFF) begin
                        nxt.seq = SQ_WARM;
                        nxt.cnt = 14'h0000;
                    end else if (cfg_new != r.cfg) begin
                        nxt.cnt = 14'h0000;
                        nxt.dbl = 1'b1;
                        nxt.div = 6'h00;
                        nxt.res_valid = 1'b0;
                    end
                end
                OFF_OFFSET_TRIM: nxt.offset = wm[15:0];
                OFF_GAIN_TRIM:   nxt.gain   = wm[15:0];
                OFF_DMA_CONTROL: begin
                    nxt.wrap = wm[DMA_WRAP_BIT];
                    if (wm[DMA_RST_BIT]) begin
                        // Reset wins over a load in the same write
                        nxt.load    = 1'b0;
                        nxt.dma_act = 1'b0;
                        nxt.dma_ovf = 1'b0;
                        nxt.idx     = 13'h0000;
                        nxt.cndt    = 13'h0000;
                        nxt.ram.valid = 1'b0;
                    end else if (wm[DMA_LOAD_BIT]) begin
                        nxt.load = 1'b1;
                    end
                end
                OFF_RESULT_COUNT: nxt.ndt = wm[12:0];
                default: begin
                end
            endcase
        end

        // A flag set in the same cycle as its clear stays set
        nxt.flags = ((r.flags & ~ev_clr) | ev_set) & EVENT_MASK;
    end

    // Single state register
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r         <= '0;
            r.seq     <= SQ_OFF;
            r.cfg     <= CFG_RESET;
            r.gain    <= GAIN_RESET;
            r.offset  <= OFFS_RESET;
        end else begin
            r <= nxt;
        end
    end

endmodule
